// *** ccpu_top.sv ***
// two capture/compare units with the third counter and a wishbone slave
`timescale 1ns/100ps
`include "ccpu_defs.svh"

// How it works
// - special mode match clears third counter if selected
// - trigger clear never sets counter overflow flag
// - software counter write beats same-cycle trigger clear
// - trigger clears whichever counter is unit timebase
// - control top bits read zero, low four mode
// - control bits 5:4 are stored and read back, otherwise unused
// - mode zero resets unit; 0001, 0011 do nothing
// - capture codes pick falling, rising, 4th, 16th
// - mode 0010 toggles pin on match, sets flag
// - 1000/1001 init pin, force opposite on match
// - mode 1010 sets flag only, pin unchanged
// - 1011 raises trigger and flag; 11xx does nothing
// - capture copies selected 16-bit timebase into value
// - capture sets flag; only software clears it
// - new capture overwrites unread value
// - counter control field chooses each unit timebase
// - edge detector watches pin even when output
// - prescaler cleared when off or not capturing
// - capture code change keeps prescaler count
// - select 1x both third, 01 split, 00 first
module ccpu_top import ccpu_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic [1:0]  unit_pin_i,
  output logic      [1:0]  unit_pin_o,
  input  wire logic [15:0] first_count_i,
  input  wire logic        count_clk_i,
  output logic             first_clear_o,
  output logic      [1:0]  special_event_o,
  output logic      [2:0]  event_flags_o
);

  // ==========================================================
  // state
  ccpu_state_t     s;
  ccpu_state_t     n;
  logic            wr;
  logic [3:0]      idx;
  logic            mapped;
  logic            tick3;
  logic            clr3;
  logic [1:0]      tb3;
  logic [1:0]      cap_ev;
  logic [1:0]      hit;
  logic [1:0]      capm;
  logic [1:0][15:0] tbv;
  logic [1:0][3:0] mode;

  assign idx    = adr_i[5:2];
  assign mapped = (adr_i[7:6] == 2'b00) && (idx <= `CCPU_IDX_FLAGS);
  // writes commit at the edge that sees ack, so each access acts once
  assign wr     = cyc_i && stb_i && we_i && s.ack && sel_i[0];

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    n.trig = 2'b00;
    n.first_clear = 1'b0;
    n.ack = cyc_i && stb_i && !s.ack;
    clr3 = 1'b0;
    // timebase select decode
    tb3[0] = s.cnt3_ctl[`CCPU_SEL_HI_BIT];
    tb3[1] = s.cnt3_ctl[`CCPU_SEL_HI_BIT]
             | s.cnt3_ctl[`CCPU_SEL_LO_BIT];
    // register read, zero for unmapped words
    if (cyc_i && stb_i && !s.ack) begin
      n.dat = 8'h00;
      if (mapped) begin
        unique case (idx)
          `CCPU_IDX_CTRL0:   n.dat = s.ctrl[0];
          `CCPU_IDX_VAL0_LO: n.dat = s.val[0][7:0];
          `CCPU_IDX_VAL0_HI: n.dat = s.val[0][15:8];
          `CCPU_IDX_CTRL1:   n.dat = s.ctrl[1];
          `CCPU_IDX_VAL1_LO: n.dat = s.val[1][7:0];
          `CCPU_IDX_VAL1_HI: n.dat = s.val[1][15:8];
          `CCPU_IDX_CNT3_LO: n.dat = s.cnt3[7:0];
          `CCPU_IDX_CNT3_HI: n.dat = s.cnt3[15:8];
          `CCPU_IDX_CNT3_CT: n.dat = s.cnt3_ctl;
          `CCPU_IDX_FLAGS:   n.dat = {5'h00, s.flags};
          default:           n.dat = 8'h00;
        endcase
      end
    end
    // software writes to unit registers; hardware events below win over all but a switch to off
    if (wr && mapped) begin
      unique case (idx)
        `CCPU_IDX_CTRL0, `CCPU_IDX_CTRL1: begin
          n.ctrl[idx == `CCPU_IDX_CTRL1] = {2'b00, dat_i[5:0]};
          if (dat_i[3:0] == `CCPU_M_OFF || dat_i[3:0] == `CCPU_M_SET_HI)
            n.pin[idx == `CCPU_IDX_CTRL1] = 1'b0;
          else if (dat_i[3:0] == `CCPU_M_SET_LO)
            n.pin[idx == `CCPU_IDX_CTRL1] = 1'b1;
        end
        `CCPU_IDX_VAL0_LO: n.val[0][7:0]  = dat_i[7:0];
        `CCPU_IDX_VAL0_HI: n.val[0][15:8] = dat_i[7:0];
        `CCPU_IDX_VAL1_LO: n.val[1][7:0]  = dat_i[7:0];
        `CCPU_IDX_VAL1_HI: n.val[1][15:8] = dat_i[7:0];
        `CCPU_IDX_CNT3_CT: n.cnt3_ctl     = dat_i[7:0];
        `CCPU_IDX_FLAGS:   n.flags        = s.flags & ~dat_i[2:0];
        default: ;
      endcase
    end
    // third counter: instruction clock or synchronous external edge
    n.clk_prev = count_clk_i;
    tick3 = s.cnt3_ctl[`CCPU_ON_BIT]
            && (!s.cnt3_ctl[`CCPU_CS_BIT] || (count_clk_i && !s.clk_prev));
    // per unit capture and compare
    for (int u = 0; u < 2; u++) begin
      mode[u] = s.ctrl[u][3:0];
      tbv[u]  = tb3[u] ? s.cnt3 : first_count_i;
      n.sync0[u] = unit_pin_i[u];
      n.sync1[u] = s.sync0[u];
      n.prev[u]  = s.sync1[u];
      capm[u] = (mode[u][3:2] == 2'b01);
      cap_ev[u] = 1'b0;
      // leaving capture by a write clears the count in the same edge
      if (!capm[u] || n.ctrl[u][3:2] != 2'b01)
        n.pscnt[u] = 4'h0;
      else if (s.sync1[u] && !s.prev[u])
        n.pscnt[u] = s.pscnt[u] + 4'h1;
      unique case (mode[u])
        `CCPU_M_FALL:   cap_ev[u] = !s.sync1[u] && s.prev[u];
        `CCPU_M_RISE:   cap_ev[u] = s.sync1[u] && !s.prev[u];
        `CCPU_M_RISE4:  cap_ev[u] = s.sync1[u] && !s.prev[u]
                                    && (s.pscnt[u][1:0] == `CCPU_PS4_LAST);
        `CCPU_M_RISE16: cap_ev[u] = s.sync1[u] && !s.prev[u]
                                    && (s.pscnt[u] == `CCPU_PS16_LAST);
        default:        cap_ev[u] = 1'b0;
      endcase
      if (cap_ev[u]) begin
        n.val[u]   = tbv[u];
        n.flags[u] = 1'b1;
      end
      // match taken once per arrival so a stalled timebase fires once
      n.match_prev[u] = (tbv[u] == s.val[u]);
      hit[u] = (tbv[u] == s.val[u]) && !s.match_prev[u]
               && (mode[u] == `CCPU_M_TOGGLE
                   || mode[u][3:2] == 2'b10);
      if (hit[u]) begin
        n.flags[u] = 1'b1;
        unique case (mode[u])
          `CCPU_M_TOGGLE:  n.pin[u] = !s.pin[u];
          `CCPU_M_SET_HI:  n.pin[u] = 1'b1;
          `CCPU_M_SET_LO:  n.pin[u] = 1'b0;
          `CCPU_M_SPECIAL: begin
            n.trig[u] = 1'b1;
            if (tb3[u])
              clr3 = 1'b1;
            else
              n.first_clear = 1'b1;
          end
          default: ;
        endcase
      end
      // switching off wins over a match in the same cycle
      if (n.ctrl[u][3:0] == `CCPU_M_OFF)
        n.pin[u] = 1'b0;
    end
    // counter update: clear beats tick, software write beats both
    if (clr3)
      n.cnt3 = 16'h0000;
    else if (tick3) begin
      n.cnt3 = s.cnt3 + 16'h0001;
      if (s.cnt3 == 16'hFFFF)
        n.flags[`CCPU_OVF_BIT] = 1'b1;
    end
    if (wr && idx == `CCPU_IDX_CNT3_LO && mapped)
      n.cnt3[7:0] = dat_i[7:0];
    if (wr && idx == `CCPU_IDX_CNT3_HI && mapped)
      n.cnt3[15:8] = dat_i[7:0];
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= {`CCPU_CTRL_RST, `CCPU_CTRL_RST};
      s.cnt3_ctl <= `CCPU_CNT3_CT_RST;
    end else begin
      s <= n;
    end
  end

  assign dat_o           = {24'h000000, s.dat};
  assign ack_o           = s.ack;
  assign unit_pin_o      = s.pin;
  assign first_clear_o   = s.first_clear;
  assign special_event_o = s.trig;
  assign event_flags_o   = s.flags;

  // ==========================================================
  // assertions
  logic       wr_cnt_q;
  logic [1:0] tb3_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_q <= 1'b0;
      tb3_q <= 2'b00;
    end else begin
      wr_cnt_q <= wr && mapped && (idx == `CCPU_IDX_CNT3_LO
                                   || idx == `CCPU_IDX_CNT3_HI);
      tb3_q <= tb3;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_trig_clears;
    |(s.trig & tb3_q) && !wr_cnt_q |-> s.cnt3 == 16'h0000;
  endproperty
  a_trig_clears: assert property (p_trig_clears)
    else $error("trigger did not clear third counter");

  property p_ovf_only_wrap;
    $rose(s.flags[`CCPU_OVF_BIT]) |-> $past(s.cnt3) == 16'hFFFF;
  endproperty
  a_ovf_only_wrap: assert property (p_ovf_only_wrap)
    else $error("overflow flag set without wrap");

  property p_write_wins;
    wr && mapped && idx == `CCPU_IDX_CNT3_LO
      |=> s.cnt3[7:0] == $past(dat_i[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost");

  property p_top_zero;
    s.ctrl[0][7:6] == 2'b00 && s.ctrl[1][7:6] == 2'b00;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("control top bits not zero");

  property p_off_pin_low;
    mode[0] == `CCPU_M_OFF |-> s.pin[0] == 1'b0 && s.pscnt[0] == 4'h0;
  endproperty
  a_off_pin_low: assert property (p_off_pin_low)
    else $error("unit off but pin or prescaler active");

  property p_capture;
    cap_ev[0] |=> s.val[0] == $past(tbv[0]) && s.flags[0];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag wrong");

  property p_flag_sw_clear;
    $fell(s.flags[0])
      |-> $past(wr && mapped && idx == `CCPU_IDX_FLAGS && dat_i[0]);
  endproperty
  a_flag_sw_clear: assert property (p_flag_sw_clear)
    else $error("event flag cleared by hardware");

  property p_toggle;
    hit[0] && mode[0] == `CCPU_M_TOGGLE && !wr
      |=> s.pin[0] != $past(s.pin[0]) && s.flags[0];
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle on match failed");

  property p_force_high;
    hit[0] && mode[0] == `CCPU_M_SET_HI && !wr |=> s.pin[0];
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("pin not forced high on match");

  property p_soft_only;
    hit[0] && mode[0] == `CCPU_M_SOFT && !wr
      |=> $stable(s.pin[0]) && s.flags[0];
  endproperty
  a_soft_only: assert property (p_soft_only)
    else $error("soft match changed pin");

  property p_prescale_kept;
    capm[0] && $past(capm[0]) && !(s.sync1[0] && !s.prev[0])
      && !wr |=> $stable(s.pscnt[0]);
  endproperty
  a_prescale_kept: assert property (p_prescale_kept)
    else $error("prescaler changed without edge");

  property p_force_low;
    hit[0] && mode[0] == `CCPU_M_SET_LO && !wr |=> !s.pin[0];
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("pin not forced low on match");

  property p_special;
    hit[0] && mode[0] == `CCPU_M_SPECIAL |=> s.trig[0] && s.flags[0];
  endproperty
  a_special: assert property (p_special)
    else $error("special match gave no trigger or flag");

  property p_first_clear;
    hit[0] && mode[0] == `CCPU_M_SPECIAL && !tb3[0] |=> s.first_clear;
  endproperty
  a_first_clear: assert property (p_first_clear)
    else $error("first counter clear missing");

  property p_capture_two;
    cap_ev[1] |=> s.val[1] == $past(tbv[1]) && s.flags[1];
  endproperty
  a_capture_two: assert property (p_capture_two)
    else $error("unit two capture value or flag wrong");

  property p_prescale_idle;
    s.ctrl[0][3:2] != 2'b01 |-> s.pscnt[0] == 4'h0;
  endproperty
  a_prescale_idle: assert property (p_prescale_idle)
    else $error("prescaler not cleared outside capture");

  property p_clear_no_ovf;
    clr3 |=> !$rose(s.flags[`CCPU_OVF_BIT]);
  endproperty
  a_clear_no_ovf: assert property (p_clear_no_ovf)
    else $error("trigger clear set overflow flag");

  property p_write_wins_hi;
    wr && mapped && idx == `CCPU_IDX_CNT3_HI
      |=> s.cnt3[15:8] == $past(dat_i[7:0]);
  endproperty
  a_write_wins_hi: assert property (p_write_wins_hi)
    else $error("counter high write lost");

  property p_off_pin_two;
    mode[1] == `CCPU_M_OFF |-> s.pin[1] == 1'b0 && s.pscnt[1] == 4'h0;
  endproperty
  a_off_pin_two: assert property (p_off_pin_two)
    else $error("unit two off but pin or prescaler active");

endmodule // ccpu_top

// *** ccpu_defs.svh ***
// register offsets, field positions and mode codes of the capture unit
`ifndef CCPU_DEFS_SVH
`define CCPU_DEFS_SVH
// ==========================================================
// register word indices (byte address = index * 4)
`define CCPU_IDX_CTRL0   4'h0
`define CCPU_IDX_VAL0_LO 4'h1
`define CCPU_IDX_VAL0_HI 4'h2
`define CCPU_IDX_CTRL1   4'h3
`define CCPU_IDX_VAL1_LO 4'h4
`define CCPU_IDX_VAL1_HI 4'h5
`define CCPU_IDX_CNT3_LO 4'h6
`define CCPU_IDX_CNT3_HI 4'h7
`define CCPU_IDX_CNT3_CT 4'h8
`define CCPU_IDX_FLAGS   4'h9
// ==========================================================
// field positions
`define CCPU_SEL_HI_BIT  6
`define CCPU_SEL_LO_BIT  3
`define CCPU_CS_BIT      1
`define CCPU_ON_BIT      0
`define CCPU_OVF_BIT     2
// ==========================================================
// mode select codes
`define CCPU_M_OFF       4'h0
`define CCPU_M_TOGGLE    4'h2
`define CCPU_M_FALL      4'h4
`define CCPU_M_RISE      4'h5
`define CCPU_M_RISE4     4'h6
`define CCPU_M_RISE16    4'h7
`define CCPU_M_SET_HI    4'h8
`define CCPU_M_SET_LO    4'h9
`define CCPU_M_SOFT      4'hA
`define CCPU_M_SPECIAL   4'hB
// ==========================================================
// prescaler terminal counts and reset values
`define CCPU_PS4_LAST    4'h3
`define CCPU_PS16_LAST   4'hF
`define CCPU_CTRL_RST    8'h00
`define CCPU_CNT3_CT_RST 8'h00
`endif

// *** ccpu_pkg.sv ***
// types of the capture/compare unit
package ccpu_pkg;
  typedef struct packed {
    logic [1:0][7:0]  ctrl;
    logic [1:0][15:0] val;
    logic [15:0]      cnt3;
    logic [7:0]       cnt3_ctl;
    logic [2:0]       flags;
    logic [1:0]       sync0;
    logic [1:0]       sync1;
    logic [1:0]       prev;
    logic [1:0][3:0]  pscnt;
    logic [1:0]       match_prev;
    logic [1:0]       pin;
    logic [1:0]       trig;
    logic             first_clear;
    logic             clk_prev;
    logic             ack;
    logic [7:0]       dat;
  } ccpu_state_t;
endpackage

// *** ccpu_src.sv ***
// stimulus source that drives the capture pins with a settable lag
`timescale 1ns/100ps
module ccpu_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] lvl_i,
  input  wire logic [3:0] dly_i,
  output logic      [1:0] pin_o
);
  logic [3:0] wait_reg;
  // a lag models a slow source; the level still moves on a clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= 2'h0;
      wait_reg <= 4'h0;
    end else if (lvl_i == pin_o) begin
      wait_reg <= 4'h0;
    end else if (wait_reg >= dly_i) begin
      pin_o    <= lvl_i;
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // ccpu_src

// *** capture_compare_capture_unit_tb.sv ***
// register-level testbench of the capture/compare units
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module capture_compare_capture_unit_tb;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, clr_o, seen, cclk;
  logic [7:0]  adr_i, d;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i;
  logic [1:0]  lvl, pin_i, pin_o, sev_o, sev_seen;
  logic [15:0] fc;
  logic [2:0]  flg_o;
  int          n_errors, num_checks, i;
  logic [7:0]  md [5]   = '{8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B};
  logic [1:0]  pn [5]   = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
  ccpu_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .unit_pin_i(pin_i),
    .unit_pin_o(pin_o), .first_count_i(fc), .count_clk_i(cclk),
    .first_clear_o(clr_o), .special_event_o(sev_o),
    .event_flags_o(flg_o));
  ccpu_src src_u (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl),
    .dly_i(4'h2), .pin_o(pin_i));
  // ==========================================================
  // bus cycles
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
    dat_i <= {24'h0, v};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    d = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus(a, 1'b1, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK($sformatf("reg%h", a), e, d)
  endtask
  task automatic pin(input logic v);
    lvl[0] <= v;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rst_i) begin
      seen     <= 1'b0;
      sev_seen <= 2'b00;
    end else begin
      if (clr_o === 1'b1) seen <= 1'b1;
      sev_seen <= sev_seen | sev_o;
    end
  end
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    rst_i = 1; we_i = 0; cyc_i = 0; stb_i = 0; adr_i = 0; dat_i = 0;
    sel_i = 4'hF; lvl = 0; fc = 0; cclk = 0; n_errors = 0; num_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h00, 8'h00);
    rc(8'h20, 8'h00);
    rc(8'h28, 8'h00);
    wr(8'h00, 8'hFF);
    rc(8'h00, 8'h3F);
    for (i = 0; i < 16; i++) begin
      wr(8'h00, 8'(i));
      rc(8'h00, 8'(i));
    end
    // mode changes may raise the flag, so it is cleared afterwards
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h05);
    wr(8'h24, 8'h07);
    fc <= 16'h1234;
    pin(1'b1);
    rc(8'h04, 8'h34);
    rc(8'h08, 8'h12);
    rc(8'h24, 8'h01);
    fc <= 16'hABCD;
    pin(1'b0);
    pin(1'b1);
    rc(8'h04, 8'hCD);
    rc(8'h24, 8'h01);
    wr(8'h24, 8'h01);
    rc(8'h24, 8'h00);
    wr(8'h00, 8'h04);
    wr(8'h24, 8'h01);
    fc <= 16'h5555;
    pin(1'b0);
    rc(8'h04, 8'h55);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h06);
    wr(8'h24, 8'h01);
    for (i = 0; i < 3; i++) begin
      pin(1'b1);
      pin(1'b0);
    end
    rc(8'h24, 8'h00);
    fc <= 16'h0077;
    pin(1'b1);
    rc(8'h04, 8'h77);
    // the prescale count survives a direct code change
    wr(8'h00, 8'h07);
    wr(8'h24, 8'h01);
    pin(1'b0);
    pin(1'b1);
    rc(8'h24, 8'h00);
    // a kept count reaches sixteen after eleven more rising edges
    for (i = 0; i < 10; i++) begin
      pin(1'b0);
      pin(1'b1);
    end
    rc(8'h24, 8'h00);
    pin(1'b0);
    pin(1'b1);
    rc(8'h24, 8'h01);
    for (i = 0; i < 5; i++) begin
      wr(8'h00, 8'h00);
      fc <= 16'h0000;
      wr(8'h04, 8'h10);
      wr(8'h08, 8'h00);
      wr(8'h00, md[i]);
      wr(8'h24, 8'h01);
      `CHK("init_pin", md[i] == 8'h09, pin_o[0])
      fc <= 16'h0010;
      repeat (4) @(posedge clk_i);
      `CHK("match_pin", pn[i][0], pin_o[0])
      rc(8'h24, 8'h01);
    end
    `CHK("first_clear", 1'b1, seen)
    `CHK("trigger", 2'b01, sev_seen)
    wr(8'h00, 8'h00);
    wr(8'h24, 8'h07);
    wr(8'h10, 8'h40);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h0C, 8'h0B);
    wr(8'h20, 8'h09);
    repeat (300) @(posedge clk_i);
    rc(8'h1C, 8'h00);
    rc(8'h24, 8'h02);
    `CHK("flag_pins", 3'h2, flg_o)
    `CHK("trigger", 2'b11, sev_seen)
    wr(8'h20, 8'h01);
    wr(8'h24, 8'h07);
    wr(8'h1C, 8'hFF);
    wr(8'h18, 8'hF0);
    repeat (30) @(posedge clk_i);
    rc(8'h24, 8'h04);
    `CHK("flag_pins", 3'h4, flg_o)
    wr(8'h20, 8'h03);
    wr(8'h1C, 8'h00);
    wr(8'h18, 8'h00);
    repeat (5) begin
      cclk <= 1'b1;
      @(posedge clk_i);
      cclk <= 1'b0;
      @(posedge clk_i);
    end
    rc(8'h18, 8'h05);
    end_of_test();
  end
endmodule // capture_compare_capture_unit_tb
